// file: hw/drc_pkg.sv
// drc_pkg: register map, field positions and source encodings of the
// reference converter control block.
// assumes: included nowhere, referenced as drc_pkg::name.
package drc_pkg;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] CONTROL_ADDR = 8'h00;   // converter_control
    localparam logic [7:0] LEVEL_ADDR   = 8'h04;   // converter_level_select
    localparam logic [7:0] PIN_ADDR     = 8'h08;   // pin read view

    // ----------------------------------------------------------------
    // converter_control fields
    // ----------------------------------------------------------------
    localparam int EN_BIT  = 7;
    localparam int LPS_BIT = 6;
    localparam int OE_BIT  = 5;
    localparam int PSS_HI  = 3;
    localparam int PSS_LO  = 2;
    localparam int NSS_BIT = 0;
    localparam logic [7:0] CONTROL_MASK  = 8'hED;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // ----------------------------------------------------------------
    // converter_level_select fields
    // ----------------------------------------------------------------
    localparam int LEVEL_W = 5;
    localparam logic [7:0] LEVEL_MASK  = 8'h1F;
    localparam logic [7:0] LEVEL_RESET = 8'h00;

    // ----------------------------------------------------------------
    // source encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DRC_PSRC_SUPPLY   = 2'h0,
        DRC_PSRC_EXT_REF  = 2'h1,
        DRC_PSRC_FIXED    = 2'h2,
        DRC_PSRC_RESERVED = 2'h3
    } drc_psrc_t;

endpackage : drc_pkg

// file: hw/drc_source_decode.sv
// drc_source_decode: registered one-hot ladder source selections.
// assumes: sys_clk domain, reset already synchronised.
`timescale 1ns/1ps
module drc_source_decode (
    input  wire logic       sys_clk,         // system clock
    input  wire logic       rst_sync_n,      // synchronised reset
    input  wire logic [1:0] psel_code,       // positive source code
    input  wire logic       nsel_code,       // negative source code
    output logic      [2:0] pos_onehot,      // supply, ext ref, fixed ref
    output logic      [1:0] neg_onehot       // ground, ext neg ref
);
    wire logic [2:0] pos_next;
    wire logic [1:0] neg_next;

    // reserved code selects nothing, so the ladder top floats rather than shorts
    assign pos_next = (psel_code == drc_pkg::DRC_PSRC_SUPPLY)  ? 3'h1 :
                      (psel_code == drc_pkg::DRC_PSRC_EXT_REF) ? 3'h2 :
                      (psel_code == drc_pkg::DRC_PSRC_FIXED)   ? 3'h4 : 3'h0; // R8
    assign neg_next = nsel_code ? 2'h2 : 2'h1;                               // R9

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pos_onehot <= 3'h0;
            neg_onehot <= 2'h0;
        end else begin
            pos_onehot <= pos_next;                                          // R15
            neg_onehot <= neg_next;
        end
    end
endmodule : drc_source_decode

// file: hw/drc_top.sv
// drc_top: control registers of the 32-level reference converter behind APB.
// assumes: APB master on sys_clk; rst_n is the device reset (all types).
// Operation
// R1: negative clamp: off, lps0, nss, code 0
// R2: sleep wake leaves control register untouched
// R3: software should disable before sleep
// R4: any reset clears enable, pin, code
// R5: bit 7 turns converter on
// R6: bit 6 picks low-power source
// R7: bit 5 routes voltage to pin
// R8: bits 3:2 pick positive source
// R9: bit 0 picks negative source
// R10: bits 4,1 ignore writes, read zero
// R11: level register bits 7:5 read zero
// R12: five-bit code picks ladder tap
// R13: positive clamp: off, lps1, pss, ones
// R14: routed pin: driver off, reads zero
// R15: writes act at completing edge, registered; source selects and pin routing (pin_route_reg) take effect one edge later
`timescale 1ns/1ps
module drc_top (
    input  wire logic        sys_clk,          // 100 MHz system clock
    input  wire logic        rst_n,            // async device reset
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb enable
    input  wire logic        pwrite,           // apb direction
    input  wire logic [7:0]  paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    output logic      [31:0] prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb error
    input  wire logic        sleep_wake,       // wake from sleep pulse
    input  wire logic        pin_in,           // raw pin level
    input  wire logic        pin_dig_out,      // port driver data
    input  wire logic        pin_dig_oe,       // port driver enable
    output logic             pin_out,          // pin digital drive
    output logic             pin_oe,           // pin digital enable
    output logic             pin_input_en,     // pin input detector on
    output logic             pin_analog_en,    // ladder tied to pin
    output logic             converter_enable, // ladder powered
    output logic             low_power_state_select, // held source
    output logic      [4:0]  level_code,       // ladder tap
    output logic      [2:0]  pos_source_sel,   // one-hot positive
    output logic      [1:0]  neg_source_sel    // one-hot negative
);
    // ----------------------------------------------------------------
    // reset synchroniser
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // pin input synchroniser
    // ----------------------------------------------------------------
    logic pin_meta_reg;
    logic pin_sync_reg;

    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [7:0] level_reg;
    logic [7:0] level_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        err_reg;

    wire logic setup_w    = psel & ~penable;
    wire logic access_w   = psel & penable;
    wire logic hit_ctrl   = (paddr == drc_pkg::CONTROL_ADDR);
    wire logic hit_level  = (paddr == drc_pkg::LEVEL_ADDR);
    wire logic hit_pin    = (paddr == drc_pkg::PIN_ADDR);
    wire logic mapped     = hit_ctrl | hit_level | hit_pin;
    wire logic wr_ctrl    = access_w & pwrite & hit_ctrl;
    wire logic wr_level   = access_w & pwrite & hit_level;

    // answer one cycle after setup: access phase always ends in one cycle
    assign pready  = psel & penable;
    assign prdata  = rdata_reg;
    assign pslverr = psel & penable & err_reg;

    // ----------------------------------------------------------------
    // register next values
    // ----------------------------------------------------------------
    // sleep_wake is deliberately unused in the next-state terms
    assign control_next = wr_ctrl ? (pwdata[7:0] & drc_pkg::CONTROL_MASK)  // R5 R6 R7 R8 R9 R10
                                  : control_reg;                            // R2
    assign level_next   = wr_level ? (pwdata[7:0] & drc_pkg::LEVEL_MASK)   // R11 R12
                                   : level_reg;

    wire logic oe_bit_w = control_reg[drc_pkg::OE_BIT];
    wire logic pin_rd_w = oe_bit_w ? 1'b0 : pin_sync_reg;                  // R14

    assign rdata_next = hit_ctrl  ? {24'h000000, control_reg} :
                        hit_level ? {24'h000000, level_reg}   :
                        hit_pin   ? {31'h00000000, pin_rd_w}  : 32'h00000000;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // writes land at the access edge, the one at which the master sees
    // pready, so a setup that is never completed cannot change control_reg or level_reg
    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            control_reg <= drc_pkg::CONTROL_RESET;                         // R4
            level_reg   <= drc_pkg::LEVEL_RESET;                           // R4
            rdata_reg   <= 32'h00000000;
            err_reg     <= 1'b0;
        end else begin
            control_reg <= control_next;                                   // R15
            level_reg   <= level_next;                                     // R15
            if (setup_w) begin
                rdata_reg <= pwrite ? 32'h00000000 : rdata_next;
                err_reg   <= ~mapped | (pwrite & hit_pin);
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs to ladder and pin
    // ----------------------------------------------------------------
    logic pin_route_reg;

    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pin_route_reg <= 1'b0;                                         // R4
        end else begin
            pin_route_reg <= oe_bit_w;                                     // R7
        end
    end

    assign converter_enable       = control_reg[drc_pkg::EN_BIT];          // R5
    assign low_power_state_select = control_reg[drc_pkg::LPS_BIT];         // R6
    assign level_code             = level_reg[drc_pkg::LEVEL_W-1:0];       // R12
    assign pin_analog_en          = pin_route_reg;                         // R7
    // digital driver and detector are overridden while the ladder owns the pin
    assign pin_oe                 = pin_dig_oe & ~pin_route_reg;           // R14
    assign pin_out                = pin_dig_out & ~pin_route_reg;          // R14
    assign pin_input_en           = ~pin_route_reg;                        // R14

    drc_source_decode u_decode (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_reg),
        .psel_code  (control_reg[drc_pkg::PSS_HI:drc_pkg::PSS_LO]),
        .nsel_code  (control_reg[drc_pkg::NSS_BIT]),
        .pos_onehot (pos_source_sel),
        .neg_onehot (neg_source_sel)
    );
endmodule : drc_top

// file: verif/drc_properties.sv
// drc_properties: port-level checks of the reference converter control block.
// assumes: bound onto drc_top, one sys_clk domain, rst_n low means reset.
`timescale 1ns/1ps
module drc_properties (
    input wire logic        sys_clk,                // clock
    input wire logic        rst_n,                  // reset
    input wire logic        psel,                   // apb
    input wire logic        penable,                // apb
    input wire logic        pwrite,                 // apb
    input wire logic [7:0]  paddr,                  // apb
    input wire logic [31:0] pwdata,                 // apb
    input wire logic [31:0] prdata,                 // apb
    input wire logic        pready,                 // apb
    input wire logic        pslverr,                // apb
    input wire logic        sleep_wake,             // wake pulse
    input wire logic        pin_oe,                 // pin drive
    input wire logic        pin_input_en,           // pin detector
    input wire logic        pin_analog_en,          // routed
    input wire logic        converter_enable,       // ladder on
    input wire logic        low_power_state_select, // held source
    input wire logic [4:0]  level_code,             // tap
    input wire logic [2:0]  pos_source_sel,         // one-hot
    input wire logic [1:0]  neg_source_sel          // one-hot
);
    wire acc = psel && penable;
    wire wc  = acc && pwrite && paddr == drc_pkg::CONTROL_ADDR;
    wire wl  = acc && pwrite && paddr == drc_pkg::LEVEL_ADDR;
    wire rc  = acc && !pwrite && paddr == drc_pkg::CONTROL_ADDR;
    wire bad = acc && paddr != drc_pkg::CONTROL_ADDR && paddr != drc_pkg::LEVEL_ADDR && paddr != drc_pkg::PIN_ADDR;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_ready_access: assert property (pready == acc) else $error("pready not tied to access");
    chk_enable_write: assert property (wc |=> converter_enable == $past(pwdata[7])) else $error("enable");
    chk_lps_write: assert property (wc |=> low_power_state_select == $past(pwdata[6])) else $error("lps");
    chk_level_write: assert property (wl |=> level_code == $past(pwdata[4:0])) else $error("level");
    chk_pos_decode: assert property (wc |-> ##2 pos_source_sel == ($past(pwdata[3:2], 2) == 2'h3 ? 3'h0 :
        3'h1 << $past(pwdata[3:2], 2))) else $error("positive source");
    chk_neg_decode: assert property (wc |-> ##2 neg_source_sel == ($past(pwdata[0], 2) ? 2'h2 : 2'h1))
        else $error("negative source");
    chk_pin_route: assert property (wc |-> ##2 pin_analog_en == $past(pwdata[5], 2)) else $error("route");
    chk_pin_override: assert property (pin_analog_en |-> !pin_oe && !pin_input_en) else $error("override");
    chk_unimpl_zero: assert property (rc |-> prdata[4] == 1'b0 && prdata[1] == 1'b0) else $error("ctl gaps");
    chk_level_zero: assert property (acc && !pwrite && paddr == drc_pkg::LEVEL_ADDR |-> prdata[7:5] == 3'h0)
        else $error("level gaps");
    chk_unmapped_err: assert property (bad |-> pslverr) else $error("no error on unmapped");
    chk_wake_hold: assert property (sleep_wake && !psel |=> $stable(converter_enable) && $stable(level_code))
        else $error("wake changed state");
    chk_setup_no_write: assert property (psel && !penable && pwrite && paddr == drc_pkg::CONTROL_ADDR
        |=> $stable(converter_enable)) else $error("write landed before access");
    chk_reset_clear: assert property (disable iff (1'b0) !rst_n |=> !converter_enable && level_code == 5'h0
        && !pin_analog_en) else $error("reset");
    cover property (wc);
    cover property (bad && pslverr);
    cover property (pin_analog_en);
endmodule : drc_properties

bind drc_top drc_properties u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_wake(sleep_wake), .pin_oe(pin_oe), .pin_input_en(pin_input_en), .pin_analog_en(pin_analog_en),
    .converter_enable(converter_enable), .low_power_state_select(low_power_state_select),
    .level_code(level_code), .pos_source_sel(pos_source_sel), .neg_source_sel(neg_source_sel));

// file: verif/tb_dac_reference_control.sv
// tb_dac_reference_control: random register traffic plus clamp, wake, error and reset cases.
// assumes: drc_top answers APB with pready in the access cycle.
`timescale 1ns/1ps
module tb_dac_reference_control;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sleep_wake = 0;
    logic pin_in = 0, pin_dig_out = 0, pin_dig_oe = 0, pslverr, pready, pin_out, pin_oe, pin_input_en, pin_analog_en;
    logic converter_enable, low_power_state_select, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, d, seed;
    logic [4:0] level_code;
    logic [2:0] pos_source_sel;
    logic [1:0] neg_source_sel;
    int err_count = 0, total_checks = 0;
    always #5 sys_clk = ~sys_clk;
    drc_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_wake(sleep_wake), .pin_in(pin_in), .pin_dig_out(pin_dig_out), .pin_dig_oe(pin_dig_oe),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_input_en(pin_input_en), .pin_analog_en(pin_analog_en),
        .converter_enable(converter_enable), .low_power_state_select(low_power_state_select),
        .level_code(level_code), .pos_source_sel(pos_source_sel), .neg_source_sel(neg_source_sel));
    function automatic logic [2:0] pos_exp(input logic [1:0] c);
        return (c == 2'h3) ? 3'h0 : 3'h1 << c;
    endfunction : pos_exp
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk
    // psel is kept high between calls so transfers can run back to back
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        penable <= 1'b0;
    endtask : apb
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    initial begin
        #300000;
        err_count++;
        close_out();
    end
    initial begin
        seed = 32'hd6a37703;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(0, drc_pkg::CONTROL_ADDR, 0); chk("control reset", 0, r);
        apb(0, drc_pkg::LEVEL_ADDR, 0); chk("level reset", 0, r);
        for (int i = 0; i < 48; i++) begin
            d = $random(seed);
            d[3:2] = 2'((i / 2) % 3);
            {pin_in, pin_dig_out, pin_dig_oe} <= d[10:8];
            apb(1, (i % 2) ? drc_pkg::LEVEL_ADDR : drc_pkg::CONTROL_ADDR, d);
            apb(0, (i % 2) ? drc_pkg::LEVEL_ADDR : drc_pkg::CONTROL_ADDR, 0);
            if (i % 2) begin
                chk("level read", d & 32'h1F, r);
                chk("level code", d[4:0], level_code);
            end else begin
                chk("control read", d & 32'hED, r);
                chk("outputs", {d[7:5], d[0], pos_exp(d[3:2])}, {converter_enable, low_power_state_select,
                    pin_analog_en, neg_source_sel[1], pos_source_sel});
                chk("pin drive", d[5] ? 3'h0 : {d[8], d[9], 1'b1}, {pin_oe, pin_out, pin_input_en});
                apb(0, drc_pkg::PIN_ADDR, 0);
                chk("pin read", d[5] ? 0 : d[10], r);
            end
        end
        apb(1, 8'h0C, 32'hFF); chk("unmapped", 1, e);
        apb(1, drc_pkg::PIN_ADDR, 32'h1); chk("pin write", 1, e);
        apb(1, drc_pkg::CONTROL_ADDR, 32'h01); apb(1, drc_pkg::LEVEL_ADDR, 32'h00);
        apb(0, drc_pkg::LEVEL_ADDR, 0);
        chk("negative clamp", {2'h0, 5'h00, 2'h2}, {converter_enable, low_power_state_select, level_code,
            neg_source_sel});
        apb(1, drc_pkg::CONTROL_ADDR, 32'h81);
        psel <= 1'b0; sleep_wake <= 1'b1;
        @(posedge sys_clk); sleep_wake <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("wake", {1'b1, 2'h2, 5'h0}, {converter_enable, neg_source_sel, level_code});
        apb(0, drc_pkg::CONTROL_ADDR, 0); chk("wake control", 32'h81, r);
        apb(1, drc_pkg::CONTROL_ADDR, 32'h48); apb(1, drc_pkg::LEVEL_ADDR, 32'h1F);
        apb(0, drc_pkg::LEVEL_ADDR, 0);
        chk("positive clamp", {1'b0, 1'b1, 5'h1F, 3'h4}, {converter_enable, low_power_state_select,
            level_code, pos_source_sel});
        apb(1, drc_pkg::CONTROL_ADDR, 32'hA0);
        psel <= 1'b0;
        @(posedge sys_clk); rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("reset", 0, {converter_enable, level_code, pin_analog_en, neg_source_sel});
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(0, drc_pkg::CONTROL_ADDR, 0); chk("control after reset", 0, r);
        apb(0, drc_pkg::LEVEL_ADDR, 0); chk("level after reset", 0, r);
        psel <= 1'b0;
        close_out();
    end
endmodule : tb_dac_reference_control
